// [dpm_pkg.sv]
package dpm_pkg;

    // Operating modes, Gray coded along shutdown, standby, acquire, receive, drain
    typedef enum logic [2:0] {
        DPM_SHUTDOWN = 3'h0,
        DPM_STANDBY  = 3'h1,
        DPM_ACQUIRE  = 3'h3,
        DPM_RECEIVE  = 3'h2,
        DPM_DRAIN    = 3'h6
    } dpm_mode_e;

    // One parallel output word
    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
        logic       vertical_sync;
        logic       horizontal_sync;
        logic       pixel_valid_flag;
    } dpm_pixel_s;

    // Pins sampled from outside the clock domain
    typedef struct packed {
        logic receiver_enable_pin;  // Enable pin level
        logic link_clk;             // Serial clock, sampled as a level
        logic cm_above_ratio;       // Common mode above 0.9 of link supply, or floating
        logic cm_below_limit;       // Common mode below 1.3 V
        logic pll_locked;           // Lock flag of the receive PLL
        logic pll_clk;              // Recovered pixel clock of the PLL
        logic link_select;          // Low one lane, high two lanes
    } dpm_pins_s;

    // Power switches handed to the analog and datapath blocks
    typedef struct packed {
        logic input_stage_on;       // Pin input buffers
        logic core_on;              // Bias and switching circuitry
        logic monitor_on;           // Clock activity monitor
        logic pll_on;               // Receive PLL
        logic lane_zero_on;         // Serial lane zero receiver
        logic lane_one_on;          // Serial lane one receiver
    } dpm_power_s;

    // Static pattern: colours and syncs high, valid flag low
    localparam dpm_pixel_s DPM_STATIC_PIXEL = '{
        red: 8'hff, green: 8'hff, blue: 8'hff,
        vertical_sync: 1'b1, horizontal_sync: 1'b1, pixel_valid_flag: 1'b0
    };
    localparam dpm_power_s DPM_POWER_OFF = '{
        input_stage_on: 1'b1, core_on: 1'b0, monitor_on: 1'b0,
        pll_on: 1'b0, lane_zero_on: 1'b0, lane_one_on: 1'b0
    };

    // Timing figures and derived cycle counts
    localparam int DPM_CLK_PERIOD_NS = 40;
    localparam int DPM_CLK_KHZ       = 25000;
    localparam int DPM_EN_HOLD_NS    = 10000;
    localparam int DPM_EN_HOLD_CYC   = (DPM_EN_HOLD_NS + DPM_CLK_PERIOD_NS - 1) / DPM_CLK_PERIOD_NS;
    localparam int DPM_FAST_KHZ      = 3000;
    localparam int DPM_FAST_GAP_CYC  = DPM_CLK_KHZ / DPM_FAST_KHZ;
    localparam int DPM_SLOW_KHZ      = 500;
    localparam int DPM_SLOW_GAP_CYC  = (DPM_CLK_KHZ + DPM_SLOW_KHZ - 1) / DPM_SLOW_KHZ;

    // Lane widths per pixel clock
    localparam logic [4:0] DPM_ONE_LANE_BITS = 5'h1e;
    localparam logic [4:0] DPM_TWO_LANE_BITS = 5'h0f;

    localparam int DPM_CNT_W = 16;

endpackage

// [dpm_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module dpm_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    // Three stages: catch, settle, edge history
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } dpm_sync_s;

    dpm_sync_s st_r;    // Registered stages
    dpm_sync_s st_nxt;  // Next stages

    // Shift; only the second stage reads the first
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Edges taken from settled stages only
    assign level = st_r.s2;
    assign rise  = st_r.s2 & ~st_r.s3;
    assign fall  = ~st_r.s2 & st_r.s3;
endmodule
`default_nettype wire

// [dpm_power_mode_fsm.sv]
// Operation
// RULE1 - Enable low beyond 10 us forces shutdown
// RULE2 - Shutdown: circuitry off, static output pattern
// RULE3 - Enable high 10 us, common mode high: standby
// RULE4 - Standby: monitor only, PLL off, static
// RULE5 - Shutdown to standby starts activity monitor
// RULE6 - Clock activity in standby starts acquire
// RULE7 - Lock within wait time, lanes per select
// RULE8 - Static pattern until first recovered word
// RULE9 - Receive only with enable and lock
// RULE10 - Transmitter raises common mode to request standby
// RULE11 - Standby request disables outputs within sleep time
// RULE12 - Static pattern on next PLL falling edge
// RULE13 - PLL off after static, monitor stays on
// RULE14 - Long enable low: static then shutdown
// RULE15 - Input stages stay alive in shutdown
// RULE16 - Active only: enable, clock above 3 MHz, low common mode
// RULE17 - Clock below 500 kHz falls to standby
// RULE18 - One lane 30 bits, two lanes 15
// RULE19 - Wait, sleep and hold times are parameters; the enable-high hold for standby is fixed at DPM_EN_HOLD_CYC
`timescale 1ns/1ps
`default_nettype none
module dpm_power_mode_fsm #(
    parameter int LOCK_WAIT_CYC = 2000,                      // Lock wait time in cycles, see RULE19
    parameter int SLEEP_CYC     = 64,                        // Standby entry time in cycles, see RULE19
    parameter int PWRDN_CYC     = dpm_pkg::DPM_EN_HOLD_CYC   // Shutdown hold time in cycles, see RULE19
) (
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire dpm_pkg::dpm_pins_s  pins,
    input  wire logic                word_valid,
    input  wire dpm_pkg::dpm_pixel_s word,
    output logic                     pixel_clock_out,
    output dpm_pkg::dpm_pixel_s      pixel_out,
    output dpm_pkg::dpm_power_s      power,
    output logic [4:0]               lane_bits,
    output dpm_pkg::dpm_mode_e       mode
);
    localparam int CW = dpm_pkg::DPM_CNT_W;

    // Whole controller state
    typedef struct packed {
        dpm_pkg::dpm_mode_e  mode;        // Operating mode
        logic                en_lvl;      // Enable level last seen
        logic [CW-1:0]       en_cnt;      // Cycles at that level
        logic [CW-1:0]       gap_cnt;     // Cycles since last link clock rise
        logic                clk_fast;    // Link clock above 3 MHz
        logic                clk_slow;    // Link clock below 500 kHz or stopped
        logic [CW-1:0]       tmr;         // Lock wait or sleep timer
        logic                first_seen;  // First word recovered
        dpm_pkg::dpm_pixel_s last_word;   // Latest recovered word
        dpm_pkg::dpm_pixel_s pixel;       // Output bus
        logic                pclk;        // Output pixel clock
        dpm_pkg::dpm_power_s power;       // Power switches
        logic [4:0]          lane_bits;   // Bits per lane per pixel clock
    } dpm_state_s;

    localparam dpm_state_s RESET_STATE = '{
        mode: dpm_pkg::DPM_SHUTDOWN, en_lvl: 1'b0, en_cnt: '0, gap_cnt: '0,
        clk_fast: 1'b0, clk_slow: 1'b1, tmr: '0, first_seen: 1'b0,
        last_word: dpm_pkg::DPM_STATIC_PIXEL, pixel: dpm_pkg::DPM_STATIC_PIXEL,
        pclk: 1'b0, power: dpm_pkg::DPM_POWER_OFF, lane_bits: dpm_pkg::DPM_ONE_LANE_BITS
    };

    dpm_state_s         st_r;     // Registered state
    dpm_state_s         st_nxt;   // Next state
    dpm_pkg::dpm_pins_s pin_lvl;  // Synchronised pin levels
    dpm_pkg::dpm_pins_s pin_rise; // Rising edges
    dpm_pkg::dpm_pins_s pin_fall; // Falling edges

    // Saturating increment shared by all counters
    function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
        sat_inc = (v == {CW{1'b1}}) ? v : CW'(v + 1'b1);
    endfunction

    // Every pin passes two flops before use
    dpm_sync #(
        .W ($bits(dpm_pkg::dpm_pins_s))
    ) u_sync (
        .clk   (clk),
        .reset (reset),
        .d     (pins),
        .level (pin_lvl),
        .rise  (pin_rise),
        .fall  (pin_fall)
    );

    logic en_high_ok;  // Enable held high long enough
    logic en_low_long; // Enable held low past shutdown hold
    logic cm_request;  // Transmitter asks for standby
    logic link_ok;     // Conditions for the active path

    assign en_high_ok  = st_r.en_lvl && (st_r.en_cnt >= CW'(dpm_pkg::DPM_EN_HOLD_CYC));
    assign en_low_long = !st_r.en_lvl && (st_r.en_cnt >= CW'(PWRDN_CYC));
    assign cm_request  = pin_lvl.cm_above_ratio;  // see RULE10
    assign link_ok     = pin_lvl.receiver_enable_pin && st_r.clk_fast && pin_lvl.cm_below_limit
                         && !cm_request;

    // Next state: filters, monitor, mode walk and outputs
    always_comb begin
        st_nxt = st_r;
        // Enable level filter
        if (pin_lvl.receiver_enable_pin != st_r.en_lvl) begin
            st_nxt.en_lvl = pin_lvl.receiver_enable_pin;
            st_nxt.en_cnt = CW'(1);
        end else begin
            st_nxt.en_cnt = sat_inc(st_r.en_cnt);
        end
        // Activity monitor: measure the gap between clock rises
        if (st_r.mode == dpm_pkg::DPM_SHUTDOWN) begin
            // Monitor is powered down, forget any activity
            st_nxt.gap_cnt  = '0;
            st_nxt.clk_fast = 1'b0;
            st_nxt.clk_slow = 1'b1;
        end else if (pin_rise.link_clk) begin
            st_nxt.gap_cnt  = '0;
            st_nxt.clk_fast = st_r.gap_cnt < CW'(dpm_pkg::DPM_FAST_GAP_CYC);  // see RULE16
            st_nxt.clk_slow = st_r.gap_cnt >= CW'(dpm_pkg::DPM_SLOW_GAP_CYC); // see RULE17
        end else begin
            st_nxt.gap_cnt = sat_inc(st_r.gap_cnt);
            // Clock stopped: no rise within the slow period
            if (st_r.gap_cnt >= CW'(dpm_pkg::DPM_SLOW_GAP_CYC)) begin
                st_nxt.clk_fast = 1'b0;
                st_nxt.clk_slow = 1'b1; // see RULE17
            end else if (st_r.gap_cnt >= CW'(dpm_pkg::DPM_FAST_GAP_CYC)) begin
                // Rise overdue: a paused clock must not keep a stale fast flag
                st_nxt.clk_fast = 1'b0; // see RULE16
            end
        end
        // Latest recovered word, kept for the bus
        if (word_valid && (st_r.mode == dpm_pkg::DPM_RECEIVE)) begin
            st_nxt.last_word  = word;
            st_nxt.first_seen = 1'b1;
        end
        // Mode walk; a long low enable wins over all else
        if (en_low_long) begin
            st_nxt.mode = dpm_pkg::DPM_SHUTDOWN; // see RULE1 see RULE14
        end else begin
            case (st_r.mode)
                dpm_pkg::DPM_SHUTDOWN: begin
                    // Wake into standby once enable is steady high
                    if (en_high_ok) begin
                        st_nxt.mode = dpm_pkg::DPM_STANDBY; // see RULE3 see RULE5
                    end
                end
                dpm_pkg::DPM_STANDBY: begin
                    // Activity seen: start the PLL
                    if (link_ok) begin
                        st_nxt.mode = dpm_pkg::DPM_ACQUIRE; // see RULE6 see RULE16
                        st_nxt.tmr  = '0;
                    end
                end
                dpm_pkg::DPM_ACQUIRE: begin
                    if (!link_ok || st_r.clk_slow) begin
                        st_nxt.mode = dpm_pkg::DPM_STANDBY; // see RULE3 see RULE17
                    end else if (pin_lvl.pll_locked) begin
                        st_nxt.mode       = dpm_pkg::DPM_RECEIVE; // see RULE7
                        st_nxt.first_seen = 1'b0;
                    end else if (st_r.tmr >= CW'(LOCK_WAIT_CYC)) begin
                        // Lock never came; retry from standby
                        st_nxt.mode = dpm_pkg::DPM_STANDBY; // see RULE7
                    end else begin
                        st_nxt.tmr = sat_inc(st_r.tmr);
                    end
                end
                dpm_pkg::DPM_RECEIVE: begin
                    // Receive holds only with enable, lock and live clock
                    if (cm_request || st_r.clk_slow || !pin_lvl.pll_locked
                        || !pin_lvl.receiver_enable_pin) begin
                        st_nxt.mode = dpm_pkg::DPM_DRAIN; // see RULE9 see RULE11
                        st_nxt.tmr  = '0;
                    end
                end
                dpm_pkg::DPM_DRAIN: begin
                    // Wait for a PLL falling edge, but never past the sleep time
                    if (pin_fall.pll_clk || (st_r.tmr >= CW'(SLEEP_CYC))) begin
                        st_nxt.mode = dpm_pkg::DPM_STANDBY; // see RULE12 see RULE11
                    end else begin
                        st_nxt.tmr = sat_inc(st_r.tmr);
                    end
                end
                default: begin
                    st_nxt.mode = dpm_pkg::DPM_SHUTDOWN;
                end
            endcase
        end
        // Output bus from the mode being entered
        if (((st_nxt.mode == dpm_pkg::DPM_RECEIVE) || (st_nxt.mode == dpm_pkg::DPM_DRAIN))
            && st_nxt.first_seen) begin
            st_nxt.pixel = st_nxt.last_word;               // see RULE8 see RULE9
            st_nxt.pclk  = pin_lvl.pll_clk;
        end else begin
            st_nxt.pixel = dpm_pkg::DPM_STATIC_PIXEL;      // see RULE2 see RULE4 see RULE6
            st_nxt.pclk  = 1'b0;
        end
        // Power switches follow the mode
        st_nxt.power.input_stage_on = 1'b1;                // see RULE15
        st_nxt.power.core_on        = st_nxt.mode != dpm_pkg::DPM_SHUTDOWN; // see RULE2
        st_nxt.power.monitor_on     = st_nxt.mode != dpm_pkg::DPM_SHUTDOWN; // see RULE5 see RULE13
        st_nxt.power.pll_on         = (st_nxt.mode == dpm_pkg::DPM_ACQUIRE)
                                      || (st_nxt.mode == dpm_pkg::DPM_RECEIVE)
                                      || (st_nxt.mode == dpm_pkg::DPM_DRAIN); // see RULE4 see RULE13
        st_nxt.power.lane_zero_on   = (st_nxt.mode == dpm_pkg::DPM_RECEIVE)
                                      || (st_nxt.mode == dpm_pkg::DPM_DRAIN); // see RULE7
        st_nxt.power.lane_one_on    = st_nxt.power.lane_zero_on && pin_lvl.link_select; // see RULE7
        st_nxt.lane_bits            = pin_lvl.link_select ? dpm_pkg::DPM_TWO_LANE_BITS
                                                          : dpm_pkg::DPM_ONE_LANE_BITS; // see RULE18
    end

    // Single state register, synchronous reset
    always_ff @(posedge clk) begin
        if (reset) begin
            st_r <= RESET_STATE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state flops
    assign pixel_out       = st_r.pixel;
    assign pixel_clock_out = st_r.pclk;
    assign power           = st_r.power;
    assign lane_bits       = st_r.lane_bits;
    assign mode            = st_r.mode;

    // Checks
    localparam int SLEEP_B = SLEEP_CYC + 2;

    // Check helper: cycles spent in acquire; a counter, as the lock wait may exceed a delay range
    logic [CW-1:0] acq_age_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            acq_age_r <= '0;
        end else if (st_r.mode == dpm_pkg::DPM_ACQUIRE) begin
            acq_age_r <= sat_inc(acq_age_r);
        end else begin
            acq_age_r <= '0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Idle modes keep the static pattern and a quiet pixel clock
    chk_static_idle: assert property ( // see RULE2
        (st_r.mode != dpm_pkg::DPM_RECEIVE && st_r.mode != dpm_pkg::DPM_DRAIN)
        |-> (pixel_out == dpm_pkg::DPM_STATIC_PIXEL) && !pixel_clock_out)
        else $error("static pattern missing outside receive");
    chk_shutdown_power: assert property ((st_r.mode == dpm_pkg::DPM_SHUTDOWN) // see RULE2
        |-> !power.pll_on && !power.monitor_on && !power.core_on)
        else $error("circuitry on in shutdown");
    chk_standby_power: assert property ((st_r.mode == dpm_pkg::DPM_STANDBY) // see RULE4
        |-> !power.pll_on && power.monitor_on && !power.lane_zero_on)
        else $error("standby power switches wrong");
    chk_enable_low: assert property ((!st_r.en_lvl && st_r.en_cnt >= CW'(PWRDN_CYC)) // see RULE1
        |=> (st_r.mode == dpm_pkg::DPM_SHUTDOWN))
        else $error("no shutdown after long enable low");
    chk_wake_standby: assert property ((st_r.mode == dpm_pkg::DPM_SHUTDOWN) ##1 // see RULE3
        (st_r.mode != dpm_pkg::DPM_SHUTDOWN) |-> (st_r.mode == dpm_pkg::DPM_STANDBY)
        && $past(st_r.en_cnt, 2) >= CW'(dpm_pkg::DPM_EN_HOLD_CYC) - CW'(1))
        else $error("shutdown left early or not to standby");
    chk_acquire_entry: assert property ((st_r.mode == dpm_pkg::DPM_STANDBY) ##1 // see RULE16
        (st_r.mode == dpm_pkg::DPM_ACQUIRE) |-> $past(st_r.clk_fast) && $past(pin_lvl.cm_below_limit))
        else $error("acquire entered without a fast clock");
    chk_lock_wait: assert property ((st_r.mode == dpm_pkg::DPM_ACQUIRE) // see RULE7
        |-> (acq_age_r <= CW'(LOCK_WAIT_CYC)))
        else $error("acquire outlived the lock wait");
    chk_first_word: assert property ((st_r.mode == dpm_pkg::DPM_RECEIVE && !st_r.first_seen) // see RULE8
        |-> (pixel_out == dpm_pkg::DPM_STATIC_PIXEL))
        else $error("bus left static before first word");
    chk_lane_select: assert property (power.lane_one_on |-> power.lane_zero_on // see RULE18
        && (lane_bits == dpm_pkg::DPM_TWO_LANE_BITS))
        else $error("lane one on in one lane mode");

    sequence s_drain_entry;
        (st_r.mode == dpm_pkg::DPM_RECEIVE) ##1 (st_r.mode == dpm_pkg::DPM_DRAIN);
    endsequence
    sequence s_drain_exit;
        ##[1:SLEEP_B] ((st_r.mode != dpm_pkg::DPM_DRAIN) && (pixel_out == dpm_pkg::DPM_STATIC_PIXEL));
    endsequence
    chk_sleep_bound: assert property (s_drain_entry |-> s_drain_exit) // see RULE11
        else $error("outputs not static within sleep time");
    chk_inputs_alive: assert property (power.input_stage_on) // see RULE15
        else $error("input stage switched off");
endmodule
`default_nettype wire

// [dpm_tx_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dpm_tx_model (
    input  wire logic active,         // Transmitter sending frames
    input  wire logic slow,           // Clock below the low-frequency limit
    output var  logic link_clk,       // Serial clock level
    output var  logic cm_above_ratio, // Common mode raised or floating
    output var  logic cm_below_limit  // Common mode in the active range
);
    // Clock runs only in frames; idle clock rests at its pull-up level
    initial begin
        link_clk = 1'b1;
        #37;
        forever begin
            #(slow ? 1200 : 160);
            link_clk = active ? ~link_clk : 1'b1;
        end
    end

    // Idle output floats, so the pull-up lifts the common mode
    always_comb begin
        cm_above_ratio = ~active;
        cm_below_limit = active;
    end
endmodule
`default_nettype wire

// [test_dpm_power_mode_fsm.sv]
`timescale 1ns/1ps
`default_nettype none
module test_dpm_power_mode_fsm;
    localparam int LOCK_WAIT = 20; // Short lock wait keeps the run brief
    localparam int SLEEP     = 16; // Longer than a PLL fall, so the edge path shows
    localparam int PWRDN     = 8;  // Short shutdown hold time
    localparam dpm_pkg::dpm_power_s PWR_STBY = 6'h38; // Inputs, core, monitor
    localparam dpm_pkg::dpm_power_s PWR_ACQ  = 6'h3c; // Standby plus PLL

    logic                clk;         // System clock
    logic                reset;       // Synchronous reset
    logic                en;          // Receiver enable pin
    logic                pll_locked;  // Lock flag in place of the PLL
    logic                pll_clk;     // Recovered clock stand-in
    logic                link_select; // Lane count select
    logic                tx_active;   // Transmitter sending
    logic                tx_slow;     // Transmitter clock too slow
    logic                link_clk;    // From the transmitter
    logic                cm_above;    // From the transmitter
    logic                cm_below;    // From the transmitter
    logic                word_valid;  // Recovered word strobe
    dpm_pkg::dpm_pixel_s word;        // Recovered word
    dpm_pkg::dpm_pins_s  pins;        // Packed pin bundle
    logic                pixel_clock_out;
    dpm_pkg::dpm_pixel_s pixel_out;
    dpm_pkg::dpm_power_s power;
    logic [4:0]          lane_bits;
    dpm_pkg::dpm_mode_e  mode;
    int                  mismatches;
    int                  num_checks;

    assign pins = {en, link_clk, cm_above, cm_below, pll_locked, pll_clk, link_select};

    dpm_power_mode_fsm #(.LOCK_WAIT_CYC(LOCK_WAIT), .SLEEP_CYC(SLEEP), .PWRDN_CYC(PWRDN)) dpm_power_mode_fsm_i (
        .clk(clk), .reset(reset), .pins(pins), .word_valid(word_valid), .word(word),
        .pixel_clock_out(pixel_clock_out), .pixel_out(pixel_out), .power(power),
        .lane_bits(lane_bits), .mode(mode));

    dpm_tx_model dpm_tx_model_i (.active(tx_active), .slow(tx_slow), .link_clk(link_clk),
        .cm_above_ratio(cm_above), .cm_below_limit(cm_below));

    // System clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Fast stand-in for the recovered clock, so falling edges come soon
    always @(posedge clk) pll_clk <= ~pll_clk;

    task automatic fail(input string msg);
        mismatches++;
        $display("unexpected at %0t ns: %s", $time, msg);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Bounded wait until mode equals, or differs from, the given one
    task automatic wait_mode(input dpm_pkg::dpm_mode_e m, input bit eq, input int lim, input string msg);
        int n;
        n = 0;
        while (((mode === m) != eq) && n < lim) begin
            cycles(1);
            n++;
        end
        num_checks++;
        if ((mode === m) != eq) fail(msg);
    endtask

    // Static bus, clock low and given power switches
    task automatic check_out(input dpm_pkg::dpm_power_s pw, input string msg);
        num_checks++;
        if (pixel_out !== dpm_pkg::DPM_STATIC_PIXEL || pixel_clock_out !== 1'b0 || power !== pw) fail(msg);
    endtask

    task automatic check_pix(input dpm_pkg::dpm_pixel_s px, input string msg);
        num_checks++;
        if (pixel_out !== px) fail(msg);
    endtask

    task automatic t_reset_state();
        check_out(dpm_pkg::DPM_POWER_OFF, "reset outputs");
        num_checks++;
        if (mode !== dpm_pkg::DPM_SHUTDOWN || lane_bits !== dpm_pkg::DPM_ONE_LANE_BITS) fail("reset mode");
    endtask

    // Short enable pulse ignored, then a long one reaches standby
    task automatic t_wake();
        @(posedge clk);
        en <= 1'b1;
        cycles(200);
        @(posedge clk);
        en <= 1'b0;
        cycles(300);
        wait_mode(dpm_pkg::DPM_SHUTDOWN, 1'b1, 1, "short enable woke");
        @(posedge clk);
        en <= 1'b1;
        cycles(240);
        wait_mode(dpm_pkg::DPM_SHUTDOWN, 1'b1, 1, "early standby");
        wait_mode(dpm_pkg::DPM_STANDBY, 1'b1, 30, "no standby");
        check_out(PWR_STBY, "standby outputs");
    endtask

    // Activity wakes the PLL, lock brings receive, first word reaches the bus
    task automatic t_acquire(input logic ls, input dpm_pkg::dpm_pixel_s w);
        logic pc; // Pixel clock sample
        @(posedge clk);
        link_select <= ls;
        tx_active <= 1'b1;
        tx_slow <= 1'b0;
        wait_mode(dpm_pkg::DPM_ACQUIRE, 1'b1, 100, "no acquire");
        check_out(PWR_ACQ, "acquire outputs");
        @(posedge clk);
        word_valid <= 1'b1;
        word <= w;
        @(posedge clk);
        word_valid <= 1'b0;
        cycles(2);
        check_pix(dpm_pkg::DPM_STATIC_PIXEL, "word shown in acquire");
        @(posedge clk);
        pll_locked <= 1'b1;
        wait_mode(dpm_pkg::DPM_RECEIVE, 1'b1, 10, "no receive");
        num_checks++;
        if (power.lane_zero_on !== 1'b1 || power.lane_one_on !== ls ||
            lane_bits !== (ls ? dpm_pkg::DPM_TWO_LANE_BITS : dpm_pkg::DPM_ONE_LANE_BITS)) fail("lanes");
        check_pix(dpm_pkg::DPM_STATIC_PIXEL, "bus before first word");
        @(posedge clk);
        word_valid <= 1'b1;
        @(posedge clk);
        word_valid <= 1'b0;
        cycles(2);
        check_pix(w, "first word");
        pc = pixel_clock_out;
        cycles(1);
        num_checks++;
        if (pixel_clock_out === pc) fail("pixel clock not running");
    endtask

    // Transmitter floats its outputs to ask for standby
    task automatic t_sleep();
        @(posedge clk);
        tx_active <= 1'b0;
        wait_mode(dpm_pkg::DPM_STANDBY, 1'b1, 12, "late standby");
        check_out(PWR_STBY, "sleep outputs");
        @(posedge clk);
        pll_locked <= 1'b0;
    endtask

    task automatic t_slow();
        @(posedge clk);
        tx_slow <= 1'b1;
        wait_mode(dpm_pkg::DPM_RECEIVE, 1'b0, 120, "slow clock kept receive");
        @(posedge clk);
        pll_locked <= 1'b0;
        wait_mode(dpm_pkg::DPM_STANDBY, 1'b1, 80, "slow clock no standby");
    endtask

    // No lock: acquire lasts the full wait, then gives up
    task automatic t_timeout();
        @(posedge clk);
        tx_slow <= 1'b0;
        wait_mode(dpm_pkg::DPM_ACQUIRE, 1'b1, 100, "no reacquire");
        cycles(LOCK_WAIT - 1);
        wait_mode(dpm_pkg::DPM_ACQUIRE, 1'b1, 1, "lock wait cut short");
        wait_mode(dpm_pkg::DPM_ACQUIRE, 1'b0, 3, "lock wait never ends");
    endtask

    // Enable low while the link still runs
    task automatic t_off();
        @(posedge clk);
        pll_locked <= 1'b1;
        wait_mode(dpm_pkg::DPM_RECEIVE, 1'b1, 60, "no receive before off");
        @(posedge clk);
        en <= 1'b0;
        wait_mode(dpm_pkg::DPM_SHUTDOWN, 1'b1, 40, "no shutdown");
        check_out(dpm_pkg::DPM_POWER_OFF, "shutdown outputs");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        mismatches = 0;
        num_checks = 0;
        reset = 1'b1;
        en = 1'b0;
        pll_locked = 1'b0;
        pll_clk = 1'b0;
        link_select = 1'b0;
        tx_active = 1'b0;
        tx_slow = 1'b0;
        word_valid = 1'b0;
        word = 27'h0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        cycles(1);
        t_reset_state();
        t_wake();
        t_acquire(1'b1, 27'h5a3c96e);
        t_sleep();
        t_acquire(1'b0, 27'h2c5a3b1);
        t_slow();
        t_timeout();
        t_off();
        stop_test();
    end

    // Hang guard, well beyond the thousand or so cycles needed
    initial begin
        #400000;
        fail("watchdog ran out");
        stop_test();
    end
endmodule
`default_nettype wire
